//--- verilog/adcr_readout.sv
// Conversion control and result readout of a 16-bit sampling converter.
// Assumes a conversion core that pushes a two's complement result by
// valid/ready; all host pins are asynchronous and synchronised here.
// What this block does
// - Output code is straight binary when format select high, two's complement when low.
// - First conversion after power-up is flagged as not valid.
// - Parallel reads keep the output register; each internal pulse or armed external rising edge shifts it one bit.
// - Internal clock mode: start on select/convert low, drive own clock, send previous.
// - External clock mode: same start; conversion internally timed, clock pin is input.
// - External mode, read enabled, idle: shift the completed result on host clock.
// - External mode, read enabled, converting: shift the previous result on host clock.
// - Both controls low when busy rises restarts conversion with an invalid result.
// - Convert commands are ignored while a conversion runs.
// - Parallel bus is driven only with read high and select low.
// - Byte select low gives upper byte, high gives lower byte.
// - Byte select may toggle anytime; bus follows it.
// - Output register content is undefined until the first conversion ends.
// - Busy rises only after the output register holds the new result.
// - Previous result stays readable for 12 us after a conversion starts.
// - Internal mode sends 16 pulses MSB first, then shows the sampled daisy bit.
// - External mode: MSB valid at first falling edge, daisy bits from 17th.
// - Select and convert are combined as levels; either may fall first.
`timescale 1ns/1ps
`include "adcr_consts.svh"
module adcr_readout #(
    parameter int DATA_W = `ADCR_DATA_W,
    parameter int HOLD_CYC = `ADCR_HOLD_CYC,
    parameter int SCLK_HALF = `ADCR_SCLK_HALF_CYC,
    parameter int SCLK_DLY = `ADCR_SCLK_DLY_CYC,
    parameter int BUF_DEPTH = `ADCR_BUF_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic rd_conv,
    input wire logic byte_sel,
    input wire logic code_format_select,
    input wire logic clock_source_select,
    input wire logic serial_shift_clock_in,
    output logic serial_shift_clock_out,
    output logic serial_shift_clock_oe,
    input wire logic tag_in,
    output logic serial_result_out,
    output logic [`ADCR_BYTE_W-1:0] parallel_result_bus,
    output logic parallel_result_bus_oe,
    output logic busy_n,
    output logic result_invalid,
    output logic conv_start,
    input wire logic [DATA_W-1:0] core_result,
    input wire logic core_valid,
    output logic core_ready
);
    import adcr_pkg::*;

    localparam int TW = $clog2(HOLD_CYC + 1);
    localparam logic [TW-1:0] HOLD_T = TW'(HOLD_CYC);
    localparam int SW = $clog2(((SCLK_DLY > SCLK_HALF) ? SCLK_DLY : SCLK_HALF) + 1);
    localparam logic [SW-1:0] HALF_T = SW'(SCLK_HALF - 1);
    localparam logic [SW-1:0] DLY_T = SW'(SCLK_DLY - 1);
    localparam int BW = $clog2(`ADCR_SER_BITS);
    localparam logic [BW-1:0] LAST_BIT = BW'(`ADCR_SER_BITS - 1);

    // Apply output coding; the core delivers two's complement
    function automatic logic [DATA_W-1:0] fmt_code(input logic [DATA_W-1:0] raw,
                                                   input logic straight);
        fmt_code = straight ? (raw ^ DATA_W'(`ADCR_SIGN_FLIP)) : raw;
    endfunction : fmt_code

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [6:0] pin_meta;
    logic [6:0] pin_sync;
    logic s_cs_n;
    logic s_rd;
    logic s_byte;
    logic s_fmt;
    logic s_clk_src;
    logic s_sclk;
    logic s_tag;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_meta <= `ADCR_PIN_IDLE;
            pin_sync <= `ADCR_PIN_IDLE;
        end else begin
            pin_meta <= {tag_in, serial_shift_clock_in, clock_source_select,
                         code_format_select, byte_sel, rd_conv, cs_n};
            pin_sync <= pin_meta;
        end
    end

    assign {s_tag, s_sclk, s_clk_src, s_fmt, s_byte, s_rd, s_cs_n} = pin_sync;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic conv_cmd;
    logic conv_cmd_d;
    logic conv_edge;
    logic read_en;
    logic s_sclk_d;
    logic sclk_rise;

    assign conv_cmd = !s_cs_n && !s_rd;
    assign conv_edge = conv_cmd && !conv_cmd_d;
    assign read_en = !s_cs_n && s_rd;
    assign sclk_rise = s_sclk && !s_sclk_d;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conv_cmd_d <= 1'b0;
            s_sclk_d <= 1'b0;
        end else begin
            conv_cmd_d <= conv_cmd;
            s_sclk_d <= s_sclk;
        end
    end

    // ------------------------------------------------------------
    // Conversion control
    // ------------------------------------------------------------
    adcr_conv_state_t conv_state;
    logic [TW-1:0] timer;
    logic rise_chk;
    logic first_conv;
    logic cur_bad;
    logic start;
    logic hold_over;
    logic do_load;
    logic ser_done;
    logic [DATA_W-1:0] buf_q;
    logic buf_valid;

    // A command still pending as busy rises restarts at once
    assign start = (conv_state == CONV_IDLE) && (conv_edge || (rise_chk && conv_cmd));
    assign hold_over = (timer >= HOLD_T);
    // Old result is kept until the hold time ends and the serial send is over
    assign do_load = (conv_state == CONV_RUN) && hold_over && ser_done && buf_valid;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conv_state <= CONV_IDLE;
            busy_n <= 1'b1;
            conv_start <= 1'b0;
            rise_chk <= 1'b0;
            timer <= '0;
        end else begin
            conv_start <= start;
            rise_chk <= 1'b0;
            case (conv_state)
                CONV_IDLE: begin
                    if (start) begin
                        conv_state <= CONV_RUN;
                        busy_n <= 1'b0;
                        timer <= '0;
                    end
                end
                CONV_RUN: begin
                    if (!hold_over) begin
                        timer <= timer + 1'b1;
                    end
                    if (do_load) begin
                        conv_state <= CONV_DONE;
                    end
                end
                CONV_DONE: begin
                    busy_n <= 1'b1;
                    rise_chk <= 1'b1;
                    conv_state <= CONV_IDLE;
                end
                default: begin
                    conv_state <= CONV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            first_conv <= 1'b1;
            cur_bad <= 1'b0;
            result_invalid <= 1'b1;
        end else begin
            if (start) begin
                cur_bad <= first_conv || rise_chk;
                first_conv <= 1'b0;
            end
            if (do_load) begin
                result_invalid <= cur_bad;
            end
        end
    end

    // ------------------------------------------------------------
    // Result buffer
    // ------------------------------------------------------------
    // Holds the core result while it waits for the hold time to end; stalls the core only when full
    adcr_buf #(
        .W(DATA_W),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk(clk),
        .rst_n(rst_n),
        .in_data(core_result),
        .in_valid(core_valid),
        .in_ready(core_ready),
        .out_data(buf_q),
        .out_valid(buf_valid),
        .out_ready(do_load)
    );

    // ------------------------------------------------------------
    // Internal serial clock
    // ------------------------------------------------------------
    adcr_ser_state_t ser_state;
    logic [SW-1:0] ser_cnt;
    logic [BW-1:0] bit_cnt;
    logic int_shift;

    assign ser_done = (ser_state == SER_OFF);
    assign int_shift = (ser_state == SER_LOW) && (ser_cnt == HALF_T);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ser_state <= SER_OFF;
            ser_cnt <= '0;
            bit_cnt <= '0;
            serial_shift_clock_out <= 1'b0;
        end else begin
            case (ser_state)
                SER_OFF: begin
                    serial_shift_clock_out <= 1'b0;
                    if (start && !s_clk_src) begin
                        ser_state <= SER_DELAY;
                        ser_cnt <= '0;
                        bit_cnt <= '0;
                    end
                end
                SER_DELAY: begin
                    if (ser_cnt == DLY_T) begin
                        ser_state <= SER_HIGH;
                        ser_cnt <= '0;
                        serial_shift_clock_out <= 1'b1;
                    end else begin
                        ser_cnt <= ser_cnt + 1'b1;
                    end
                end
                SER_HIGH: begin
                    if (ser_cnt == HALF_T) begin
                        ser_state <= SER_LOW;
                        ser_cnt <= '0;
                        serial_shift_clock_out <= 1'b0;
                    end else begin
                        ser_cnt <= ser_cnt + 1'b1;
                    end
                end
                SER_LOW: begin
                    // Shift at the end of the low phase, as the clock rises: data valid at the falling edge
                    if (int_shift) begin
                        ser_cnt <= '0;
                        bit_cnt <= bit_cnt + 1'b1;
                        if (bit_cnt == LAST_BIT) begin
                            ser_state <= SER_OFF;
                        end else begin
                            ser_state <= SER_HIGH;
                            serial_shift_clock_out <= 1'b1;
                        end
                    end else begin
                        ser_cnt <= ser_cnt + 1'b1;
                    end
                end
                default: begin
                    ser_state <= SER_OFF;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // External serial clock
    // ------------------------------------------------------------
    logic armed;
    logic ext_en;
    logic ext_shift;
    logic tag_hold;

    assign ext_en = s_clk_src && read_en && ser_done;
    // The first rising edge only arms, so the MSB stands for two edges
    assign ext_shift = ext_en && sclk_rise && armed;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            armed <= 1'b0;
            tag_hold <= 1'b0;
            serial_shift_clock_oe <= 1'b0;
        end else begin
            serial_shift_clock_oe <= !s_clk_src;
            if (!ext_en) begin
                armed <= 1'b0;
            end else if (sclk_rise) begin
                armed <= 1'b1;
            end
            if (start && !s_clk_src) begin
                tag_hold <= s_tag;
            end
        end
    end

    // ------------------------------------------------------------
    // Output register and pins
    // ------------------------------------------------------------
    // Zero at reset, but the host must treat it as undefined
    logic [DATA_W-1:0] out_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_reg <= '0;
        end else if (do_load) begin
            out_reg <= fmt_code(buf_q, s_fmt);
        end else if (int_shift) begin
            out_reg <= {out_reg[DATA_W-2:0], tag_hold};
        end else if (ext_shift) begin
            out_reg <= {out_reg[DATA_W-2:0], s_tag};
        end
    end

    assign serial_result_out = out_reg[DATA_W-1];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            parallel_result_bus <= '0;
            parallel_result_bus_oe <= 1'b0;
        end else begin
            parallel_result_bus_oe <= read_en;
            parallel_result_bus <= s_byte ? out_reg[`ADCR_BYTE_W-1:0]
                                          : out_reg[DATA_W-1 -: `ADCR_BYTE_W];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_fmt_load: assert property (
        do_load |=> out_reg == fmt_code($past(buf_q), $past(s_fmt)))
        else $error("loaded code does not match format select");
    chk_first_bad: assert property (
        do_load |=> result_invalid == $past(cur_bad))
        else $error("invalid flag not updated on load");
    chk_reg_stable: assert property (
        !do_load && !int_shift && !ext_shift |=> $stable(out_reg))
        else $error("output register changed without a shift or load");
    chk_int_start: assert property (
        start && !s_clk_src |=> ser_state == SER_DELAY && !busy_n)
        else $error("internal clock send did not begin at start");
    chk_ext_pin: assert property (
        s_clk_src |=> !serial_shift_clock_oe)
        else $error("clock pin driven in external mode");
    chk_ext_shift: assert property (
        ext_shift && !do_load |=> out_reg == {$past(out_reg[DATA_W-2:0]), $past(s_tag)})
        else $error("external shift wrong");
    chk_restart: assert property (
        conv_state == CONV_IDLE && rise_chk && conv_cmd |=> !busy_n && cur_bad)
        else $error("pending command at busy rise not restarted");
    chk_ignore_cmd: assert property (
        !busy_n && conv_cmd |=> !conv_start)
        else $error("command accepted while converting");
    chk_bus_oe: assert property (
        ##1 parallel_result_bus_oe == $past(read_en))
        else $error("parallel bus enable wrong");
    chk_byte_sel: assert property (
        ##1 parallel_result_bus == ($past(s_byte) ? $past(out_reg[`ADCR_BYTE_W-1:0])
                                    : $past(out_reg[DATA_W-1 -: `ADCR_BYTE_W])))
        else $error("wrong byte on parallel bus");
    chk_busy_rise: assert property (
        do_load |=> !busy_n ##1 busy_n)
        else $error("busy did not rise one cycle after load");
    chk_hold_time: assert property (
        do_load |-> timer >= HOLD_T)
        else $error("result loaded before the hold time");
    chk_int_count: assert property (
        int_shift && bit_cnt == LAST_BIT |=> ser_done && !serial_shift_clock_out)
        else $error("internal clock did not stop after the last pulse");
    chk_level_start: assert property (
        conv_state == CONV_IDLE && conv_edge |=> conv_start)
        else $error("level start not taken");

endmodule : adcr_readout

//--- verilog/adcr_consts.svh
// Constants of the converter result readout: widths, codes, timing.
// Assumes the core clock runs at ADCR_CLK_MHZ.
`ifndef ADCR_CONSTS_SVH
`define ADCR_CONSTS_SVH

`define ADCR_DATA_W 16
`define ADCR_BYTE_W 8
`define ADCR_BUF_DEPTH 2
// Synchroniser contents in reset, order {tag,sclk,clk_src,fmt,byte,rd,cs}:
// deselected, read, external clock, so no false command edge follows reset
`define ADCR_PIN_IDLE 7'h13
`define ADCR_SIGN_FLIP 16'h8000
`define ADCR_SER_BITS 16
`define ADCR_CLK_MHZ 200
// Previous result stays readable this long after a start
`define ADCR_HOLD_US 12
`define ADCR_HOLD_CYC (`ADCR_HOLD_US * `ADCR_CLK_MHZ)
// Internal serial clock period and start delay
`define ADCR_SCLK_PER_NS 1100
`define ADCR_SCLK_HALF_CYC ((`ADCR_SCLK_PER_NS / 2) * `ADCR_CLK_MHZ / 1000)
`define ADCR_SCLK_DLY_NS 1400
`define ADCR_SCLK_DLY_CYC (`ADCR_SCLK_DLY_NS * `ADCR_CLK_MHZ / 1000)

`endif

//--- verilog/adcr_pkg.sv
// Types shared by the converter result readout.
// Assumes adcr_consts.svh is on the include path.
package adcr_pkg;

    typedef enum logic [2:0] {
        CONV_IDLE = 3'h1,
        CONV_RUN = 3'h2,
        CONV_DONE = 3'h4
    } adcr_conv_state_t;

    typedef enum logic [3:0] {
        SER_OFF = 4'h1,
        SER_DELAY = 4'h2,
        SER_HIGH = 4'h4,
        SER_LOW = 4'h8
    } adcr_ser_state_t;

endpackage : adcr_pkg

//--- verilog/adcr_buf.sv
// Small flop-based FIFO with valid/ready on both sides.
// Assumes both sides run on clk; depth of at least two.
`timescale 1ns/1ps
module adcr_buf #(
    parameter int W = 16,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != FULL);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule : adcr_buf

//--- dv/adcr_host_model.sv
// Host side of the serial link: makes an external clock burst, captures data.
// Assumes the readout shifts on rising edges; data is taken at falling edges.
`timescale 1ns/1ps
module adcr_host_model (
    input wire logic go,
    input wire logic [5:0] pulses,
    input wire logic sdo,
    output logic sclk,
    output logic [31:0] bits,
    output logic done
);
    initial begin
        sclk = 1'b0;
        bits = 32'h0;
        done = 1'b0;
    end

    // ------------------------------------------------------------
    // Burst
    // ------------------------------------------------------------
    // Clock stands low between bursts so no stray shift reaches the device
    always @(posedge go) begin
        done = 1'b0;
        bits = 32'h0;
        repeat (pulses) begin
            #62.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
            bits = {bits[30:0], sdo};
        end
        done = 1'b1;
    end
endmodule : adcr_host_model

//--- dv/adcr_readout_tb_top.sv
// Testbench of the converter result readout: pin tasks and checks.
// Assumes the host model and the readout design are compiled first.
`timescale 1ns/1ps
module adcr_readout_tb_top;
    import adcr_pkg::*;
    logic clk, rst_n, cs_n, rd_conv, byte_sel, code_format_select;
    logic clock_source_select, tag_in, core_valid, hgo, have_prev;
    logic [15:0] core_result, next_val, ibits;
    logic sclk_out, sclk_oe, sdo, bus_oe, busy_n, result_invalid, conv_start, core_ready;
    logic hsclk, hdone;
    logic [7:0] bus;
    logic [31:0] hbits;
    int num_errors = 0;
    int samples_checked = 0;
    int starts = 0;
    int npulse = 0;

    adcr_readout #(.HOLD_CYC(40), .SCLK_HALF(4), .SCLK_DLY(6)) u_dut (
        .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .rd_conv(rd_conv), .byte_sel(byte_sel),
        .code_format_select(code_format_select), .clock_source_select(clock_source_select),
        .serial_shift_clock_in(sclk_oe ? sclk_out : hsclk),
        .serial_shift_clock_out(sclk_out), .serial_shift_clock_oe(sclk_oe),
        .tag_in(tag_in), .serial_result_out(sdo), .parallel_result_bus(bus),
        .parallel_result_bus_oe(bus_oe), .busy_n(busy_n), .result_invalid(result_invalid),
        .conv_start(conv_start), .core_result(core_result), .core_valid(core_valid),
        .core_ready(core_ready)
    );
    adcr_host_model u_host (
        .go(hgo), .pulses(6'h11), .sdo(sdo), .sclk(hsclk), .bits(hbits), .done(hdone)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) if (conv_start === 1'b1) starts <= starts + 1;
    always @(negedge sclk_out) begin
        npulse++;
        ibits = {ibits[14:0], sdo};
    end

    // ------------------------------------------------------------
    // Conversion core stand-in: one result per started conversion
    // ------------------------------------------------------------
    initial begin
        forever begin
            @(posedge clk iff conv_start === 1'b1);
            #1 core_result = next_val;
            core_valid = 1'b1;
            while (core_ready !== 1'b1) @(posedge clk);
            @(posedge clk);
            #1 core_valid = 1'b0;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at time %0t: got %0h, expected %0h", $time, got, exp);
        end
    endtask : check
    task automatic wait_busy_high();
        for (int n = 0; n < 500 && busy_n !== 1'b1; n++) tick(1);
        check(busy_n, 1'b1);
    endtask : wait_busy_high
    task automatic read_byte(input logic bs, input logic [7:0] exp);
        byte_sel = bs;
        cs_n = 1'b0;
        rd_conv = 1'b1;
        tick(4);
        check(bus_oe, 1'b1);
        check(bus, exp);
    endtask : read_byte
    task automatic convert(input logic cs_first, input logic [15:0] val, input logic [7:0] prev);
        int s0;
        logic [15:0] exp;
        s0 = starts;
        exp = val ^ (code_format_select ? 16'h8000 : 16'h0000);
        next_val = val;
        byte_sel = 1'b0;
        cs_n = cs_first;
        rd_conv = ~cs_first;
        tick(2);
        cs_n = 1'b0;
        rd_conv = 1'b0;
        tick(5);
        check(starts, s0 + 1);
        check(bus_oe, 1'b0);
        rd_conv = 1'b1;
        tick(5);
        if (have_prev) check(bus, prev);
        rd_conv = 1'b0;
        tick(3);
        rd_conv = 1'b1;
        tick(3);
        check(starts, s0 + 1);
        wait_busy_high();
        check(bus, exp[15:8]);
        have_prev = 1'b1;
    endtask : convert
    task automatic tally_and_finish();
        $display("errors %0d, comparisons %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #100000;
        num_errors++;
        tally_and_finish();
    end

    initial begin
        int s0;
        rst_n = 1'b0;
        cs_n = 1'b1;
        rd_conv = 1'b1;
        byte_sel = 1'b0;
        code_format_select = 1'b0;
        clock_source_select = 1'b1;
        tag_in = 1'b0;
        core_valid = 1'b0;
        core_result = 16'h0000;
        next_val = 16'h0000;
        hgo = 1'b0;
        have_prev = 1'b0;
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        tick(3);
        check(busy_n, 1'b1);
        check(core_ready, 1'b1);
        check(bus_oe, 1'b0);
        convert(1'b0, 16'h1234, 8'h00);
        check(result_invalid, 1'b1);
        read_byte(1'b1, 8'h34);
        read_byte(1'b0, 8'h12);
        cs_n = 1'b1;
        tick(4);
        check(bus_oe, 1'b0);
        code_format_select = 1'b1;
        convert(1'b1, 16'h1234, 8'h12);
        check(result_invalid, 1'b0);
        read_byte(1'b1, 8'h34);
        read_byte(1'b0, 8'h92);
        read_byte(1'b0, 8'h92);
        clock_source_select = 1'b0;
        code_format_select = 1'b0;
        tick(4);
        check(sclk_oe, 1'b1);
        npulse = 0;
        convert(1'b0, 16'h8001, 8'h92);
        check(npulse, 16);
        check(ibits, 16'h9234);
        check(sclk_out, 1'b0);
        read_byte(1'b1, 8'h01);
        clock_source_select = 1'b1;
        code_format_select = 1'b1;
        tick(4);
        check(sclk_oe, 1'b0);
        npulse = 0;
        convert(1'b0, 16'h0F0F, 8'h80);
        check(npulse, 0);
        tag_in = 1'b1;
        hgo = 1'b1;
        for (int n = 0; n < 1000 && hdone !== 1'b1; n++) tick(1);
        hgo = 1'b0;
        check(hbits[16:1], 16'h8F0F);
        check(hbits[0], 1'b1);
        read_byte(1'b0, 8'hFF);
        s0 = starts;
        next_val = 16'h5555;
        rd_conv = 1'b0;
        tick(5);
        wait_busy_high();
        tick(4);
        check(starts, s0 + 2);
        rd_conv = 1'b1;
        wait_busy_high();
        check(result_invalid, 1'b1);
        tally_and_finish();
    end
endmodule : adcr_readout_tb_top
